// ### src/css_pkg.sv
package css_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_PRECISE_PLL_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PRECISE_PLL_STAT   = 8'h04;
  localparam logic [7:0] OFS_SECOND_LOOP_MODULATED_CTRL   = 8'h08;
  localparam logic [7:0] OFS_SECOND_LOOP_MODULATED_STAT   = 8'h0C;
  localparam logic [7:0] OFS_SYSCLK      = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT    = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;
  localparam logic [7:0] OFS_MON_CTRL    = 8'h20;
  localparam logic [7:0] OFS_MON_HI      = 8'h24;
  localparam logic [7:0] OFS_MON_LO      = 8'h28;
  localparam logic [7:0] OFS_MON_FAULT   = 8'h2C;
  localparam logic [7:0] OFS_METER_CTRL  = 8'h30;
  localparam logic [7:0] OFS_METER_COUNT = 8'h34;
  localparam logic [7:0] OFS_MON_SEL     = 8'h38;

  // pll control fields
  localparam int PLLC_ENABLE_BIT  = 0;
  localparam int PLLC_IRQ_EN_BIT  = 1;
  // pll status fields
  localparam int PLLS_LOCKED_BIT  = 0;
  localparam int PLLS_LOST_BIT    = 1;

  // monitor control fields
  localparam int MONC_ENABLE_BIT  = 0;
  localparam int MONC_REFDIV_LSB  = 4;
  localparam int MONC_WIN_LSB     = 8;
  localparam int WIN_W            = 16;
  localparam int REFDIV_W         = 2;
  localparam int CNT_W            = 16;

  // fault bits in monitor fault register
  localparam int FLT_HIGH_BIT     = 0;
  localparam int FLT_LOW_BIT      = 1;
  localparam int FLT_LOSS_BIT     = 2;

  // interrupt status bits
  localparam int IRQ_PRECISE_PLL_BIT     = 0;
  localparam int IRQ_SECOND_LOOP_MODULATED_BIT     = 1;
  localparam int IRQ_MON_BIT      = 2;
  localparam int IRQ_W            = 3;

  // system clock source codes
  typedef enum logic [1:0] {
    CSS_SRC_IRC     = 2'h0,
    CSS_SRC_CRYSTAL = 2'h1,
    CSS_SRC_MODPLL  = 2'h2,
    CSS_SRC_PRECPLL = 2'h3
  } css_src_e;

  localparam int NUM_MON          = 8;
  localparam int MON_SEL_W        = 3;

  localparam logic [WIN_W-1:0] WIN_RESET = 16'h0100;
  localparam logic [CNT_W-1:0] HI_RESET  = 16'hFFFF;
  localparam logic [CNT_W-1:0] LO_RESET  = 16'h0000;

  // loss of clock: no supervised edge within this many windows of reference
  localparam int LOSS_WINDOWS     = 1;

endpackage

// ### src/css_edge_sync.sv
`timescale 1ns/100ps
// brings a foreign clock in as a level and gives one pulse per rising edge
module css_edge_sync (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      rise_pulse
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise_pulse = sync_q & ~last_q;
endmodule

// ### src/css_freq_mon.sv
`timescale 1ns/100ps
// counts supervised edges over a window of reference ticks and checks the window
module css_freq_mon #(
  parameter int CNT_W = 16,
  parameter int WIN_W = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             enable,
  input  wire logic             ref_tick,
  input  wire logic             meas_edge,
  input  wire logic [WIN_W-1:0] window_len,
  input  wire logic [CNT_W-1:0] hi_limit,
  input  wire logic [CNT_W-1:0] lo_limit,
  output logic                  too_high,
  output logic                  too_low,
  output logic                  lost,
  output logic                  done,
  output logic [CNT_W-1:0]      last_count
);
  logic [WIN_W-1:0] win_q;
  logic [CNT_W-1:0] cnt_q;
  logic             end_w;

  initial begin
    if (CNT_W < 2 || WIN_W < 2) $error("css_freq_mon: widths too small");
  end

  assign end_w = enable && ref_tick && (win_q >= window_len - WIN_W'(1));

  always_ff @(posedge clock) begin
    if (sys_rst || !enable) begin
      win_q <= '0;
      cnt_q <= '0;
    end else begin
      if (end_w) begin
        win_q <= '0;
      end else if (ref_tick) begin
        win_q <= win_q + WIN_W'(1);
      end
      if (end_w) begin
        cnt_q <= '0;
      end else if (meas_edge && cnt_q != '1) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // judgement pulses at window end; counts saturate so a runaway clock stays "high"
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      too_high   <= 1'b0;
      too_low    <= 1'b0;
      lost       <= 1'b0;
      done       <= 1'b0;
      last_count <= '0;
    end else begin
      too_high   <= end_w && (cnt_q > hi_limit);
      too_low    <= end_w && (cnt_q < lo_limit) && (cnt_q != '0);
      lost       <= end_w && (cnt_q == '0);
      done       <= end_w;
      if (end_w) begin
        last_count <= cnt_q;
      end
    end
  end
endmodule

// ### src/css_clock_supervisor.sv
`timescale 1ns/100ps
module css_clock_supervisor #(
  parameter int NUM_MON = css_pkg::NUM_MON
) (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  input  wire logic                     precise_pll_lock_in,
  input  wire logic                     second_loop_modulated_lock_in,
  input  wire logic                     crystal_ok_in,
  input  wire logic [NUM_MON-1:0]       mon_clk_in,
  output logic                          precise_pll_enable_q,
  output logic                          second_loop_modulated_enable_q,
  output logic [1:0]                    sysclk_sel_q,
  output logic                          precise_pll_fault_q,
  output logic                          second_loop_modulated_fault_q,
  output logic [NUM_MON-1:0]            mon_fault_q,
  output logic                          irq_q
);
  localparam int CW = css_pkg::CNT_W;
  localparam int WW = css_pkg::WIN_W;
  localparam int SW = css_pkg::MON_SEL_W;

  initial begin
    if (NUM_MON < 2 || NUM_MON > (1 << SW)) $error("css_clock_supervisor: bad NUM_MON");
  end

  // pll lock inputs come from foreign logic; two flops first
  logic [1:0] lock_meta_q;
  logic [1:0] lock_sync_q;
  logic [1:0] lock_last_q;
  logic [1:0] xtal_meta_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lock_meta_q <= 2'h0;
      lock_sync_q <= 2'h0;
      lock_last_q <= 2'h0;
      xtal_meta_q <= 2'h0;
    end else begin
      lock_meta_q <= {second_loop_modulated_lock_in, precise_pll_lock_in};
      lock_sync_q <= lock_meta_q;
      lock_last_q <= lock_sync_q;
      xtal_meta_q <= {xtal_meta_q[0], crystal_ok_in};
    end
  end

  logic [1:0] lol_event;
  logic [1:0] pll_en;
  assign pll_en    = {second_loop_modulated_enable_q, precise_pll_enable_q};
  assign lol_event = lock_last_q & ~lock_sync_q & pll_en;

  // write decode helpers
  logic wr_pll0c, wr_pll1c, wr_pll0s, wr_pll1s, wr_sys;
  logic wr_ist, wr_imask, wr_monc, wr_hi, wr_lo, wr_mflt, wr_meter, wr_sel;
  always_comb begin
    wr_pll0c = reg_wr && reg_addr == css_pkg::OFS_PRECISE_PLL_CTRL;
    wr_pll0s = reg_wr && reg_addr == css_pkg::OFS_PRECISE_PLL_STAT;
    wr_pll1c = reg_wr && reg_addr == css_pkg::OFS_SECOND_LOOP_MODULATED_CTRL;
    wr_pll1s = reg_wr && reg_addr == css_pkg::OFS_SECOND_LOOP_MODULATED_STAT;
    wr_sys   = reg_wr && reg_addr == css_pkg::OFS_SYSCLK;
    wr_ist   = reg_wr && reg_addr == css_pkg::OFS_IRQ_STAT;
    wr_imask = reg_wr && reg_addr == css_pkg::OFS_IRQ_MASK;
    wr_monc  = reg_wr && reg_addr == css_pkg::OFS_MON_CTRL;
    wr_hi    = reg_wr && reg_addr == css_pkg::OFS_MON_HI;
    wr_lo    = reg_wr && reg_addr == css_pkg::OFS_MON_LO;
    wr_mflt  = reg_wr && reg_addr == css_pkg::OFS_MON_FAULT;
    wr_meter = reg_wr && reg_addr == css_pkg::OFS_METER_CTRL;
    wr_sel   = reg_wr && reg_addr == css_pkg::OFS_MON_SEL;
  end

  // pll control: enable and lock lost irq enable
  logic [1:0] lol_ie_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      precise_pll_enable_q <= 1'b0;
      second_loop_modulated_enable_q <= 1'b0;
      lol_ie_q      <= 2'h0;
    end else begin
      if (wr_pll0c) begin
        precise_pll_enable_q <= reg_wdata[css_pkg::PLLC_ENABLE_BIT];
        lol_ie_q[0]   <= reg_wdata[css_pkg::PLLC_IRQ_EN_BIT];
      end
      if (wr_pll1c) begin
        second_loop_modulated_enable_q <= reg_wdata[css_pkg::PLLC_ENABLE_BIT];
        lol_ie_q[1]   <= reg_wdata[css_pkg::PLLC_IRQ_EN_BIT];
      end
    end
  end

  // sticky lock lost flags, write one to clear, new event wins; also the fault level
  logic [1:0] lol_flag_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lol_flag_q <= 2'h0;
    end else begin
      lol_flag_q[0] <= lol_event[0] |
                       (lol_flag_q[0] & ~(wr_pll0s & reg_wdata[css_pkg::PLLS_LOST_BIT]));
      lol_flag_q[1] <= lol_event[1] |
                       (lol_flag_q[1] & ~(wr_pll1s & reg_wdata[css_pkg::PLLS_LOST_BIT]));
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      precise_pll_fault_q <= 1'b0;
      second_loop_modulated_fault_q <= 1'b0;
    end else begin
      precise_pll_fault_q <= lol_flag_q[0];
      second_loop_modulated_fault_q <= lol_flag_q[1];
    end
  end

  // system clock selection; a pll source that is not locked falls back to the rc oscillator
  logic [1:0] req_src_q;
  logic       src_ok;
  always_comb begin
    case (req_src_q)
      css_pkg::CSS_SRC_MODPLL:  src_ok = lock_sync_q[1] & second_loop_modulated_enable_q;
      css_pkg::CSS_SRC_PRECPLL: src_ok = lock_sync_q[0] & precise_pll_enable_q;
      css_pkg::CSS_SRC_CRYSTAL: src_ok = xtal_meta_q[1];
      default:                  src_ok = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_src_q    <= css_pkg::CSS_SRC_IRC;
      sysclk_sel_q <= css_pkg::CSS_SRC_IRC;
    end else begin
      if (wr_sys) begin
        req_src_q <= reg_wdata[1:0];
      end
      sysclk_sel_q <= src_ok ? req_src_q : css_pkg::CSS_SRC_IRC;
    end
  end

  // clock monitors, all counted on this clock, which is the 40 MHz rc reference
  logic [NUM_MON-1:0] mon_en_q;
  logic [1:0]         refdiv_q;
  logic [WW-1:0]      win_q  [NUM_MON];
  logic [CW-1:0]      hi_q   [NUM_MON];
  logic [CW-1:0]      lo_q   [NUM_MON];
  logic [2:0]         mflt_q [NUM_MON];
  logic [SW-1:0]      sel_q;
  logic [NUM_MON-1:0] edge_w, hi_w, lo_w, lost_w, done_w;
  logic [CW-1:0]      cnt_w  [NUM_MON];
  logic [3:0]         div_q;
  logic               ref0_tick;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sel_q <= '0;
    end else if (wr_sel) begin
      sel_q <= reg_wdata[SW-1:0];
    end
  end

  // reference divider for monitor 0: 1, 2, 4 or 8 reference cycles per tick
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  always_comb begin
    case (refdiv_q)
      2'h0:    ref0_tick = 1'b1;
      2'h1:    ref0_tick = div_q[0];
      2'h2:    ref0_tick = div_q[1:0] == 2'h3;
      default: ref0_tick = div_q[2:0] == 3'h7;
    endcase
  end

  // meter: one-shot measurement on monitor 0 independent of enable
  logic meter_q;
  logic [CW-1:0] meter_cnt_q;

  for (genvar g = 0; g < NUM_MON; g++) begin : g_mon
    css_edge_sync u_sync (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .async_in   (mon_clk_in[g]),
      .rise_pulse (edge_w[g])
    );
    css_freq_mon #(.CNT_W(CW), .WIN_W(WW)) u_mon (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .enable     (mon_en_q[g] | (g == 0 && meter_q)),
      .ref_tick   (g == 0 ? ref0_tick : 1'b1),
      .meas_edge  (edge_w[g]),
      .window_len (win_q[g]),
      .hi_limit   (hi_q[g]),
      .lo_limit   (lo_q[g]),
      .too_high   (hi_w[g]),
      .too_low    (lo_w[g]),
      .lost       (lost_w[g]),
      .done       (done_w[g]),
      .last_count (cnt_w[g])
    );

    always_ff @(posedge clock) begin
      if (sys_rst) begin
        mon_en_q[g] <= 1'b0;
        win_q[g]    <= css_pkg::WIN_RESET;
        hi_q[g]     <= css_pkg::HI_RESET;
        lo_q[g]     <= css_pkg::LO_RESET;
      end else if (sel_q == SW'(g)) begin
        if (wr_monc) begin
          mon_en_q[g] <= reg_wdata[css_pkg::MONC_ENABLE_BIT];
          win_q[g]    <= reg_wdata[css_pkg::MONC_WIN_LSB +: WW];
        end
        if (wr_hi) begin
          hi_q[g] <= reg_wdata[CW-1:0];
        end
        if (wr_lo) begin
          lo_q[g] <= reg_wdata[CW-1:0];
        end
      end
    end

    // faults latch only while enabled; cleared by writing ones, set wins
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        mflt_q[g] <= 3'h0;
      end else begin
        mflt_q[g] <= ({lost_w[g], lo_w[g], hi_w[g]} & {3{mon_en_q[g]}}) |
                     (mflt_q[g] & ~({3{wr_mflt && sel_q == SW'(g)}} & reg_wdata[2:0]));
      end
    end

    always_ff @(posedge clock) begin
      if (sys_rst) begin
        mon_fault_q[g] <= 1'b0;
      end else begin
        mon_fault_q[g] <= |mflt_q[g];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      refdiv_q <= 2'h0;
    end else if (wr_monc && sel_q == '0) begin
      refdiv_q <= reg_wdata[css_pkg::MONC_REFDIV_LSB +: 2];
    end
  end

  // start bit stays set while the measured clock is absent
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meter_q     <= 1'b0;
      meter_cnt_q <= '0;
    end else if (meter_q && done_w[0] && cnt_w[0] != '0) begin
      meter_q     <= 1'b0;
      meter_cnt_q <= cnt_w[0];
    end else if (meter_q && done_w[0]) begin
      meter_q <= 1'b1;
    end else if (wr_meter && reg_wdata[0]) begin
      meter_q <= 1'b1;
    end
  end

  // interrupt status, mask and output
  logic [css_pkg::IRQ_W-1:0] ist_q;
  logic [css_pkg::IRQ_W-1:0] imask_q;
  logic [css_pkg::IRQ_W-1:0] ev;
  // only enabled monitors raise the event; the meter alone must not interrupt
  assign ev = {|((hi_w | lo_w | lost_w) & mon_en_q), lol_event & lol_ie_q};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ist_q   <= '0;
      imask_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      ist_q <= ev | (ist_q & ~({css_pkg::IRQ_W{wr_ist}} & reg_wdata[css_pkg::IRQ_W-1:0]));
      if (wr_imask) begin
        imask_q <= reg_wdata[css_pkg::IRQ_W-1:0];
      end
      irq_q <= |(ist_q & imask_q);
    end
  end

  // read data, one cycle after the strobe, zero for unmapped
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        if (reg_addr == css_pkg::OFS_PRECISE_PLL_CTRL) begin
          reg_rdata[1:0] <= {lol_ie_q[0], precise_pll_enable_q};
        end else if (reg_addr == css_pkg::OFS_PRECISE_PLL_STAT) begin
          reg_rdata[1:0] <= {lol_flag_q[0], lock_sync_q[0]};
        end else if (reg_addr == css_pkg::OFS_SECOND_LOOP_MODULATED_CTRL) begin
          reg_rdata[1:0] <= {lol_ie_q[1], second_loop_modulated_enable_q};
        end else if (reg_addr == css_pkg::OFS_SECOND_LOOP_MODULATED_STAT) begin
          reg_rdata[1:0] <= {lol_flag_q[1], lock_sync_q[1]};
        end else if (reg_addr == css_pkg::OFS_SYSCLK) begin
          reg_rdata[1:0] <= sysclk_sel_q;
        end else if (reg_addr == css_pkg::OFS_IRQ_STAT) begin
          reg_rdata[css_pkg::IRQ_W-1:0] <= ist_q;
        end else if (reg_addr == css_pkg::OFS_IRQ_MASK) begin
          reg_rdata[css_pkg::IRQ_W-1:0] <= imask_q;
        end else if (reg_addr == css_pkg::OFS_MON_CTRL) begin
          reg_rdata[0]       <= mon_en_q[sel_q];
          reg_rdata[5:4]     <= (sel_q == '0) ? refdiv_q : 2'h0;
          reg_rdata[23:8]    <= win_q[sel_q];
        end else if (reg_addr == css_pkg::OFS_MON_HI) begin
          reg_rdata[CW-1:0] <= hi_q[sel_q];
        end else if (reg_addr == css_pkg::OFS_MON_LO) begin
          reg_rdata[CW-1:0] <= lo_q[sel_q];
        end else if (reg_addr == css_pkg::OFS_MON_FAULT) begin
          reg_rdata[2:0] <= mflt_q[sel_q];
        end else if (reg_addr == css_pkg::OFS_METER_CTRL) begin
          reg_rdata[0] <= meter_q;
        end else if (reg_addr == css_pkg::OFS_METER_COUNT) begin
          reg_rdata[CW-1:0] <= meter_cnt_q;
        end else if (reg_addr == css_pkg::OFS_MON_SEL) begin
          reg_rdata[SW-1:0] <= sel_q;
        end
      end
    end
  end
endmodule

// ### tb/css_sup_asserts.sv
`timescale 1ns/100ps
module css_sup_asserts #(
  parameter int NUM_MON = 8
) (
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic               precise_pll_lock_in,
  input wire logic               second_loop_modulated_lock_in,
  input wire logic               crystal_ok_in,
  input wire logic [NUM_MON-1:0] mon_clk_in,
  input wire logic               precise_pll_enable_q,
  input wire logic               second_loop_modulated_enable_q,
  input wire logic [1:0]         sysclk_sel_q,
  input wire logic               precise_pll_fault_q,
  input wire logic               second_loop_modulated_fault_q,
  input wire logic [NUM_MON-1:0] mon_fault_q,
  input wire logic               irq_q
);
  logic [2:0]         sel_q;
  logic [NUM_MON-1:0] en_q;
  logic               flt_clr;
  logic               clr0;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  assign flt_clr = reg_wr && reg_addr == css_pkg::OFS_MON_FAULT;
  assign clr0    = reg_wr && reg_addr == css_pkg::OFS_PRECISE_PLL_STAT && reg_wdata[1];

  // shadow of the enable bits, so a fault can be tied to an enabled monitor
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sel_q <= 3'h0;
      en_q  <= '0;
    end else if (reg_wr && reg_addr == css_pkg::OFS_MON_SEL) begin
      sel_q <= reg_wdata[2:0];
    end else if (reg_wr && reg_addr == css_pkg::OFS_MON_CTRL) begin
      en_q[sel_q] <= reg_wdata[0];
    end
  end

  chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !precise_pll_enable_q
    && !second_loop_modulated_enable_q && sysclk_sel_q == 2'h0 && !precise_pll_fault_q && !second_loop_modulated_fault_q
    && mon_fault_q == '0 && !irq_q) else $error("outputs not cleared by reset");
  chk_pll_en_write: assert property (reg_wr && reg_addr == css_pkg::OFS_SECOND_LOOP_MODULATED_CTRL
    |=> second_loop_modulated_enable_q == $past(reg_wdata[0])) else $error("pll enable not written");
  chk_src_modpll: assert property (sysclk_sel_q == 2'h2 |-> second_loop_modulated_enable_q
    || $past(second_loop_modulated_enable_q)) else $error("modulated source without its pll");
  chk_src_precpll: assert property (sysclk_sel_q == 2'h3 |-> precise_pll_enable_q
    || $past(precise_pll_enable_q)) else $error("precise source without its pll");
  chk_src_readback: assert property (reg_rd && reg_addr == css_pkg::OFS_SYSCLK
    |=> reg_rdata == {30'h0, $past(sysclk_sel_q)}) else $error("source readback wrong");
  chk_lol_fault: assert property ($fell(precise_pll_lock_in) && precise_pll_enable_q
    |-> ##[3:7] precise_pll_fault_q) else $error("loss of lock not reported");
  chk_pll_fault_hold: assert property (precise_pll_fault_q && !clr0 && !$past(clr0)
    |=> precise_pll_fault_q) else $error("pll fault dropped without clear");
  chk_mon_fault_hold: assert property (!flt_clr && !$past(flt_clr) && !$past(flt_clr, 2)
    |=> (mon_fault_q & $past(mon_fault_q)) == $past(mon_fault_q))
    else $error("monitor fault dropped without clear");
  chk_mon_off_quiet: assert property ((mon_fault_q & ~$past(mon_fault_q)
    & ~(en_q | $past(en_q) | $past(en_q, 2)) & ({NUM_MON{1'b1}} << 1)) == '0)
    else $error("fault from a disabled monitor");
endmodule

bind css_clock_supervisor css_sup_asserts #(.NUM_MON(NUM_MON)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .precise_pll_lock_in(precise_pll_lock_in),
  .second_loop_modulated_lock_in(second_loop_modulated_lock_in), .crystal_ok_in(crystal_ok_in), .mon_clk_in(mon_clk_in),
  .precise_pll_enable_q(precise_pll_enable_q), .second_loop_modulated_enable_q(second_loop_modulated_enable_q), .sysclk_sel_q(sysclk_sel_q),
  .precise_pll_fault_q(precise_pll_fault_q), .second_loop_modulated_fault_q(second_loop_modulated_fault_q), .mon_fault_q(mon_fault_q),
  .irq_q(irq_q));

// ### tb/css_clk_partner.sv
`timescale 1ns/100ps
module css_clk_partner #(
  parameter int LOCK_CYC = 10
) (
  input  wire logic       clock,
  input  wire logic [1:0] pll_en,
  input  wire logic [1:0] drop,
  input  wire logic [5:0] half_cyc,
  input  wire logic [7:0] run,
  output logic      [1:0] lock,
  output logic            crystal_ok,
  output logic      [7:0] mon_clk
);
  int lk_cnt [2];
  int tg_cnt;

  initial begin
    lock    = 2'h0;
    mon_clk = 8'h00;
    crystal_ok = 1'b1;
    tg_cnt  = 0;
  end

  // a pll locks some cycles after enable; a drop is a loss-of-lock event
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      if (!pll_en[i] || drop[i]) begin
        lk_cnt[i] <= 0;
        lock[i]   <= 1'b0;
      end else if (lk_cnt[i] == LOCK_CYC) begin
        lock[i] <= 1'b1;
      end else begin
        lk_cnt[i] <= lk_cnt[i] + 1;
      end
    end
  end

  // a stopped clock stands low, as a dead oscillator would
  always @(posedge clock) begin
    if (tg_cnt + 1 >= int'(half_cyc)) begin
      tg_cnt  <= 0;
      mon_clk <= (mon_clk ^ 8'hFF) & run;
    end else begin
      tg_cnt <= tg_cnt + 1;
    end
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [23:0] HV = {6'd4, 6'd4, 6'd16, 6'd1};
  localparam logic [31:0] RV = {8'h02, 8'h00, 8'h02, 8'h02};
  localparam logic [63:0] WV = {16'h8001, 16'h4001, 16'h4001, 16'h4001};
  localparam logic [11:0] FV = {3'h1, 3'h4, 3'h2, 3'h1};
  logic        clock;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [1:0]  lock;
  logic        crystal_ok;
  logic [7:0]  mon_clk;
  logic        precise_pll_enable_q;
  logic        second_loop_modulated_enable_q;
  logic [1:0]  sysclk_sel_q;
  logic        precise_pll_fault_q;
  logic        second_loop_modulated_fault_q;
  logic [7:0]  mon_fault_q;
  logic        irq_q;
  logic [1:0]  drop;
  logic [5:0]  half_cyc;
  logic [7:0]  run;
  logic [31:0] d;
  logic [31:0] c0;
  int          n_errors;
  int          cmp_count;
  int          cyc;

  css_clock_supervisor DUT (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .precise_pll_lock_in(lock[0]),
    .second_loop_modulated_lock_in(lock[1]), .crystal_ok_in(crystal_ok), .mon_clk_in(mon_clk),
    .precise_pll_enable_q(precise_pll_enable_q), .second_loop_modulated_enable_q(second_loop_modulated_enable_q), .sysclk_sel_q(sysclk_sel_q),
    .precise_pll_fault_q(precise_pll_fault_q), .second_loop_modulated_fault_q(second_loop_modulated_fault_q), .mon_fault_q(mon_fault_q),
    .irq_q(irq_q));
  css_clk_partner u_far (
    .clock(clock), .pll_en({second_loop_modulated_enable_q, precise_pll_enable_q}), .drop(drop), .half_cyc(half_cyc),
    .run(run), .lock(lock), .crystal_ok(crystal_ok), .mon_clk(mon_clk));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic pollrd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 400; i++) begin
      rd(a);
      if ((d & m) === v) break;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // generous ceiling: every poll loop is bounded well below it
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    sys_rst   = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    drop      = 2'h0;
    half_cyc  = 6'h04;
    run       = 8'h00;
    n_errors  = 0;
    cmp_count = 0;
    cyc       = 0;
    wt(4);
    sys_rst <= 1'b0;
    rd(css_pkg::OFS_SYSCLK);
    chk(d, 32'h0);
    chk(32'({second_loop_modulated_enable_q, precise_pll_enable_q}), 32'h0);
    rd(css_pkg::OFS_MON_CTRL);
    chk(d, 32'h0001_0000);
    rd(css_pkg::OFS_MON_HI);
    chk(d, 32'h0000_FFFF);
    rd(css_pkg::OFS_MON_LO);
    chk(d, 32'h0);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C);
    chk(d, 32'h0);
    wt(300);
    chk(32'(mon_fault_q), 32'h0);
    // second_loop_modulated loses lock while the interrupt is masked, then is unmasked
    wr(css_pkg::OFS_SYSCLK, 32'h2);
    rd(css_pkg::OFS_SYSCLK);
    chk(d, 32'h0);
    wr(css_pkg::OFS_PRECISE_PLL_CTRL, 32'h1);
    wr(css_pkg::OFS_SECOND_LOOP_MODULATED_CTRL, 32'h3);
    pollrd(css_pkg::OFS_SECOND_LOOP_MODULATED_STAT, 32'h1, 32'h1);
    rd(css_pkg::OFS_SYSCLK);
    chk(d, 32'h2);
    @(posedge clock);
    drop <= 2'h2;
    wt(12);
    chk(32'({second_loop_modulated_fault_q, irq_q}), 32'h2);
    rd(css_pkg::OFS_SECOND_LOOP_MODULATED_STAT);
    chk(d & 32'h2, 32'h2);
    rd(css_pkg::OFS_SYSCLK);
    chk(d, 32'h0);
    wr(css_pkg::OFS_IRQ_MASK, 32'h7);
    wt(3);
    chk(32'(irq_q), 32'h1);
    wr(css_pkg::OFS_SECOND_LOOP_MODULATED_STAT, 32'h2);
    wr(css_pkg::OFS_IRQ_STAT, 32'h7);
    wt(4);
    chk(32'({second_loop_modulated_fault_q, irq_q}), 32'h0);
    // precise_pll without its irq enable: flag and fault, no interrupt
    @(posedge clock);
    drop <= 2'h3;
    wt(12);
    chk(32'({precise_pll_fault_q, irq_q}), 32'h2);
    rd(css_pkg::OFS_PRECISE_PLL_STAT);
    chk(d & 32'h2, 32'h2);
    wr(css_pkg::OFS_PRECISE_PLL_STAT, 32'h2);
    wt(4);
    chk(32'(precise_pll_fault_q), 32'h0);
    // monitor 1: limits before enable, then high, low, lost, longer window
    wr(css_pkg::OFS_MON_SEL, 32'h1);
    wr(css_pkg::OFS_MON_HI, 32'd12);
    wr(css_pkg::OFS_MON_LO, 32'd4);
    wr(css_pkg::OFS_MON_CTRL, 32'h0000_4001);
    @(posedge clock);
    run <= 8'h02;
    wt(250);
    rd(css_pkg::OFS_MON_FAULT);
    chk(d, 32'h0);
    for (int k = 0; k < 4; k++) begin
      // disable first so the window restarts clean and no mixed-rate window is judged
      wr(css_pkg::OFS_MON_CTRL, 32'h0);
      @(posedge clock);
      half_cyc <= HV[k*6 +: 6];
      run      <= RV[k*8 +: 8];
      wr(css_pkg::OFS_MON_CTRL, {16'h0, WV[k*16 +: 16]});
      pollrd(css_pkg::OFS_MON_FAULT, 32'h7, {29'h0, FV[k*3 +: 3]});
      chk(d, {29'h0, FV[k*3 +: 3]});
      wt(3);
      chk(32'({mon_fault_q[1], irq_q}), 32'h3);
      @(posedge clock);
      half_cyc <= 6'h04;
      run      <= 8'h02;
      wr(css_pkg::OFS_MON_CTRL, 32'h0000_4001);
      wt(250);
      chk(32'(mon_fault_q[1]), 32'h1);
      wr(css_pkg::OFS_MON_FAULT, 32'h7);
      wr(css_pkg::OFS_IRQ_STAT, 32'h7);
      wt(250);
      rd(css_pkg::OFS_MON_FAULT);
      chk({d[29:0], mon_fault_q[1], irq_q}, 32'h0);
    end
    // meter on monitor 0 with divider /1 then /8, then with the clock dead
    wr(css_pkg::OFS_MON_SEL, 32'h0);
    @(posedge clock);
    run <= 8'h01;
    for (int k = 0; k < 2; k++) begin
      wr(css_pkg::OFS_MON_CTRL, (k == 1) ? 32'h0000_4030 : 32'h0000_4000);
      wr(css_pkg::OFS_METER_CTRL, 32'h1);
      pollrd(css_pkg::OFS_METER_CTRL, 32'h1, 32'h0);
      chk(d & 32'h1, 32'h0);
      rd(css_pkg::OFS_METER_COUNT);
      if (k == 0) c0 = d;
    end
    chk(32'(d > 6 * c0 && c0 != 0), 32'h1);
    @(posedge clock);
    run <= 8'h00;
    wr(css_pkg::OFS_MON_CTRL, 32'h0000_4000);
    wr(css_pkg::OFS_METER_CTRL, 32'h1);
    wt(300);
    rd(css_pkg::OFS_METER_CTRL);
    chk(d & 32'h1, 32'h1);
    wrap_up();
  end
endmodule
